// [rtl/thsc_pkg.sv]
// Constants, states and field layout of the thermostat two-wire slave
package thsc_pkg;
    localparam int           TEMP_W         = 9;
    localparam logic [3:0]   BYTE_BITS      = 4'h8;
    // Command codes
    localparam logic [7:0]   CMD_READ_TEMP  = 8'haa;
    localparam logic [7:0]   CMD_UPPER_LIM  = 8'ha1;
    localparam logic [7:0]   CMD_LOWER_LIM  = 8'ha2;
    localparam logic [7:0]   CMD_CONFIG     = 8'hac;
    localparam logic [7:0]   CMD_START_CONV = 8'hee;
    localparam logic [7:0]   CMD_STOP_CONV  = 8'h22;
    localparam logic [7:0]   FILL_BYTE      = 8'hff;
    // Configuration/status field positions
    localparam int           CFG_DONE       = 7;
    localparam int           CFG_UPPER_TRIP = 6;
    localparam int           CFG_LOWER_TRIP = 5;
    localparam int           CFG_BUSY       = 4;
    localparam logic [1:0]   CFG_FIXED      = 2'h2;
    localparam int           CFG_POL        = 1;
    localparam int           CFG_ONESHOT    = 0;
    // Power-up contents of the nonvolatile settings
    localparam logic         POL_RST        = 1'b0;
    localparam logic         ONESHOT_RST    = 1'b0;
    localparam logic [8:0]   UPPER_RST      = 9'h050;
    localparam logic [8:0]   LOWER_RST      = 9'h014;
    // Nonvolatile write time
    localparam int           CLK_HZ         = 40_000_000;
    localparam int           NV_WRITE_MS    = 10;
    localparam int           NV_WRITE_CYC   = NV_WRITE_MS * (CLK_HZ / 1000);

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE,
        ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK, ST_IGNORE
    } thsc_state_t;
endpackage : thsc_pkg

// [rtl/thsc_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module thsc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    // Idle bus level is high, so both stages reset to 1
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic meta;
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta      <= 1'b1;
                    sync_o[g] <= 1'b1;
                end else begin
                    meta      <= async_i[g];
                    sync_o[g] <= meta;
                end
            end
        end
    endgenerate
endmodule : thsc_sync
`default_nettype wire

// [rtl/thsc_ctrl.sv]
// Conversion run control and nonvolatile busy timer
`timescale 1ns/1ps
`default_nettype none
module thsc_ctrl #(
    parameter int NV_CYC = 400000
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic start_i,
    input  wire logic stop_i,
    input  wire logic oneshot_i,
    input  wire logic temp_valid_i,
    input  wire logic nv_start_i,
    output logic      run_o,
    output logic      done_o,
    output logic      busy_o
);
    localparam int CW = $clog2(NV_CYC + 1);
    logic          stop_pend;
    logic [CW-1:0] nv_cnt;
    logic [CW-1:0] next_nv_cnt;
    logic          next_run;
    logic          conv_end;

    // A conversion ends for good in single mode or after a stop request
    assign conv_end    = temp_valid_i && (oneshot_i || stop_pend);
    assign next_run    = start_i ? 1'b1 : (conv_end ? 1'b0 : run_o);
    assign next_nv_cnt = nv_start_i ? CW'(NV_CYC)
                       : (nv_cnt != '0 ? nv_cnt - CW'(1) : nv_cnt);

    // Run, stop and done state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_o     <= 1'b0;
            stop_pend <= 1'b0;
            done_o    <= 1'b1;
        end else begin
            run_o     <= next_run;
            stop_pend <= stop_i ? run_o : (temp_valid_i || start_i ? 1'b0 : stop_pend);
            done_o    <= (start_i && !run_o) ? 1'b0 : (temp_valid_i ? 1'b1 : done_o);
        end
    end

    // Restarting the timer on a second write keeps busy honest
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nv_cnt <= '0;
            busy_o <= 1'b0;
        end else begin
            nv_cnt <= next_nv_cnt;
            busy_o <= next_nv_cnt != '0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    done_means_run_a: assert property (!done_o |-> run_o)
        else $error("done low while no conversion runs");
    oneshot_ends_a: assert property (temp_valid_i && oneshot_i && !start_i |=> !run_o)
        else $error("single mode kept converting");
    start_runs_a: assert property (start_i && !run_o |=> run_o && !done_o)
        else $error("start did not begin a conversion");
    stop_latch_a: assert property (stop_i && run_o |=> stop_pend)
        else $error("stop request while running was lost");
    stop_finish_a: assert property (stop_pend && temp_valid_i && !start_i |=> !run_o)
        else $error("stop did not idle after the conversion");
    nv_busy_a: assert property (nv_start_i |=> busy_o [*8])
        else $error("busy not held after a nonvolatile write");
endmodule : thsc_ctrl
`default_nettype wire

// [rtl/thsc_top.sv]
// Two-wire slave, command decoder and thermostat of the thermometer block
`timescale 1ns/1ps
`default_nettype none
module thsc_top
    import thsc_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE_CODE = 4'h5,        // Arbitrary value
    parameter int         NV_CYC        = NV_WRITE_CYC
) (
    input  wire logic              CLK_SYS_I,
    input  wire logic              RST_N_I,
    input  wire logic              SCL_I,
    input  wire logic              SDA_I,
    output logic                   SDA_O,
    output logic                   SDA_OE_O,
    input  wire logic [2:0]        ADDR_SELECT_I,
    input  wire logic [TEMP_W-1:0] TEMP_I,
    input  wire logic              TEMP_VALID_I,
    output logic                   CONV_RUN_O,
    output logic                   ALARM_OUTPUT_O
);
    // Synchronised pins and their previous samples
    logic [4:0]        sync_w;
    logic              scl_s;
    logic              sda_s;
    logic [2:0]        addr_s;
    logic              scl_d;
    logic              sda_d;
    // Bus engine
    thsc_state_t       state;
    thsc_state_t       next_state;
    logic [3:0]        cnt;
    logic [3:0]        next_cnt;
    logic [7:0]        sh;
    logic [7:0]        next_sh;
    logic              oe;
    logic              next_oe;
    logic              rw;
    logic              m_ack;
    logic [7:0]        cmd;
    logic [1:0]        wr_idx;
    logic              rd_idx;
    logic [7:0]        hi_byte;
    // Settings and results
    logic [TEMP_W-1:0] temp_q;
    logic [TEMP_W-1:0] upper_q;
    logic [TEMP_W-1:0] lower_q;
    logic              pol_q;
    logic              oneshot_q;
    logic              upper_trip;
    logic              lower_trip;
    logic              alarm_q;
    logic              done_w;
    logic              busy_w;

    // Pins cross into the system clock through two flops
    thsc_sync #(.WIDTH(5)) u_sync (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .async_i ({SCL_I, SDA_I, ADDR_SELECT_I}),
        .sync_o  (sync_w)
    );
    assign scl_s  = sync_w[4];
    assign sda_s  = sync_w[3];
    assign addr_s = sync_w[2:0];

    // Edge and condition decode; 40 MHz gives many samples per 400 kHz bit
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_c  = scl_s && scl_d && sda_d && !sda_s;
    assign stop_c   = scl_s && scl_d && !sda_d && sda_s;

    // Byte and command decode
    logic byte_in;
    logic addr_hit;
    logic addr_acc;
    logic wr_done;
    logic cmd_wr;
    logic upper_wr;
    logic lower_wr;
    logic cfg_wr;
    logic load_tx;
    assign byte_in  = cnt == BYTE_BITS;
    assign addr_hit = sh[7:4] == DEV_TYPE_CODE && sh[3:1] == addr_s;
    assign addr_acc = scl_fall && state == ST_ADDR && byte_in && addr_hit;
    assign wr_done  = scl_fall && state == ST_WR_BYTE && byte_in;
    assign cmd_wr   = wr_done && wr_idx == 2'h0;
    assign upper_wr = wr_done && wr_idx == 2'h2 && cmd == CMD_UPPER_LIM;
    assign lower_wr = wr_done && wr_idx == 2'h2 && cmd == CMD_LOWER_LIM;
    assign cfg_wr   = wr_done && wr_idx == 2'h1 && cmd == CMD_CONFIG;
    assign load_tx  = scl_fall && ((state == ST_ADDR_ACK && rw)
                                   || (state == ST_RD_ACK && m_ack));

    // Read data; high byte first, half-degree bit on top of the low byte
    logic [7:0] cfg_rd;
    logic [7:0] tx_byte;
    assign cfg_rd  = {done_w, upper_trip, lower_trip, busy_w,
                      CFG_FIXED, pol_q, oneshot_q};
    assign tx_byte = (cmd == CMD_READ_TEMP) ?
                         (rd_idx ? {temp_q[0], 7'h00} : temp_q[8:1])
                   : (cmd == CMD_UPPER_LIM) ?
                         (rd_idx ? {upper_q[0], 7'h00} : upper_q[8:1])
                   : (cmd == CMD_LOWER_LIM) ?
                         (rd_idx ? {lower_q[0], 7'h00} : lower_q[8:1])
                   : (cmd == CMD_CONFIG) ? cfg_rd : FILL_BYTE;

    // Bus engine next state; START and STOP override any bit in flight
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_sh    = sh;
        next_oe    = oe;
        if (start_c) begin
            next_state = ST_ADDR;
            next_cnt   = 4'h0;
            next_oe    = 1'b0;
        end else if (stop_c) begin
            next_state = ST_IDLE;
            next_oe    = 1'b0;
        end else if (scl_rise) begin
            if (state == ST_ADDR || state == ST_WR_BYTE) begin
                next_sh  = {sh[6:0], sda_s};
                next_cnt = cnt + 4'h1;
            end
        end else if (scl_fall) begin
            case (state)
                ST_ADDR: begin
                    if (byte_in) begin
                        next_state = addr_hit ? ST_ADDR_ACK : ST_IGNORE;
                        next_oe    = addr_hit;
                    end
                end
                ST_WR_BYTE: begin
                    if (byte_in) begin
                        next_state = ST_WR_ACK;
                        next_oe    = 1'b1;
                    end
                end
                ST_ADDR_ACK, ST_WR_ACK, ST_RD_ACK: begin
                    next_oe    = 1'b0;
                    next_cnt   = 4'h0;
                    next_state = (state == ST_RD_ACK) ? ST_IGNORE : ST_WR_BYTE;
                    if (load_tx) begin
                        next_state = ST_RD_BYTE;
                        next_sh    = {tx_byte[6:0], 1'b0};
                        next_oe    = !tx_byte[7];
                        next_cnt   = 4'h1;
                    end
                end
                ST_RD_BYTE: begin
                    if (byte_in) begin
                        next_state = ST_RD_ACK;
                        next_oe    = 1'b0;
                    end else begin
                        next_oe  = !sh[7];
                        next_sh  = {sh[6:0], 1'b0};
                        next_cnt = cnt + 4'h1;
                    end
                end
                default: ;
            endcase
        end
    end

    // Bus engine registers; data line is only ever pulled low
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state <= ST_IDLE;
            cnt   <= 4'h0;
            sh    <= 8'h00;
            oe    <= 1'b0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            SDA_O <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            sh    <= next_sh;
            oe    <= next_oe;
            scl_d <= scl_s;
            sda_d <= sda_s;
            SDA_O <= 1'b0;
        end
    end
    assign SDA_OE_O = oe;

    // Transfer bookkeeping: direction, command, byte indices
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rw      <= 1'b0;
            m_ack   <= 1'b0;
            cmd     <= 8'h00;
            wr_idx  <= 2'h0;
            rd_idx  <= 1'b0;
            hi_byte <= 8'h00;
        end else begin
            if (addr_acc) begin
                rw     <= sh[0];
                rd_idx <= 1'b0;
                wr_idx <= 2'h0;
            end
            if (scl_rise && state == ST_RD_ACK)
                m_ack <= !sda_s;
            if (load_tx)
                rd_idx <= 1'b1;
            if (wr_done && wr_idx != 2'h3)
                wr_idx <= wr_idx + 2'h1;
            if (cmd_wr)
                cmd <= sh;
            if (wr_done && wr_idx == 2'h1)
                hi_byte <= sh;
        end
    end

    // Limits, settings and latest result
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            upper_q   <= UPPER_RST;
            lower_q   <= LOWER_RST;
            pol_q     <= POL_RST;
            oneshot_q <= ONESHOT_RST;
            temp_q    <= '0;
        end else begin
            if (upper_wr)
                upper_q <= {hi_byte, sh[7]};
            if (lower_wr)
                lower_q <= {hi_byte, sh[7]};
            if (cfg_wr) begin
                pol_q     <= sh[CFG_POL];
                oneshot_q <= sh[CFG_ONESHOT];
            end
            if (TEMP_VALID_I)
                temp_q <= TEMP_I;
        end
    end

    // Comparisons against the fresh result, signed
    logic hot;
    logic cold;
    logic below;
    logic next_upper_trip;
    logic next_lower_trip;
    logic next_alarm;
    assign hot   = $signed(TEMP_I) >= $signed(upper_q);
    assign cold  = $signed(TEMP_I) <= $signed(lower_q);
    assign below = $signed(TEMP_I) < $signed(lower_q);
    // Set wins over a clear written in the same cycle; writing 1 changes nothing
    assign next_upper_trip = (TEMP_VALID_I && hot)
                           || (upper_trip && !(cfg_wr && !sh[CFG_UPPER_TRIP]));
    assign next_lower_trip = (TEMP_VALID_I && cold)
                           || (lower_trip && !(cfg_wr && !sh[CFG_LOWER_TRIP]));
    // Hysteresis: between limits the previous state holds
    assign next_alarm = !TEMP_VALID_I ? alarm_q
                      : (hot ? 1'b1 : (below ? 1'b0 : alarm_q));

    // Thermostat state and alarm pin
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            upper_trip     <= 1'b0;
            lower_trip     <= 1'b0;
            alarm_q        <= 1'b0;
            ALARM_OUTPUT_O <= !POL_RST;
        end else begin
            upper_trip     <= next_upper_trip;
            lower_trip     <= next_lower_trip;
            alarm_q        <= next_alarm;
            ALARM_OUTPUT_O <= pol_q ? alarm_q : !alarm_q;
        end
    end

    // Conversion control and nonvolatile timer
    thsc_ctrl #(.NV_CYC(NV_CYC)) u_ctrl (
        .clk_i        (CLK_SYS_I),
        .rst_n_i      (RST_N_I),
        .start_i      (cmd_wr && sh == CMD_START_CONV),
        .stop_i       (cmd_wr && sh == CMD_STOP_CONV),
        .oneshot_i    (oneshot_q),
        .temp_valid_i (TEMP_VALID_I),
        .nv_start_i   (upper_wr || lower_wr || cfg_wr),
        .run_o        (CONV_RUN_O),
        .done_o       (done_w),
        .busy_o       (busy_w)
    );

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_hot;
        TEMP_VALID_I && hot;
    endsequence
    sequence s_cold;
        TEMP_VALID_I && cold;
    endsequence

    start_seen_a: assert property (start_c |=> state == ST_ADDR && !oe)
        else $error("START not recognised");
    stop_seen_a: assert property (stop_c |=> state == ST_IDLE && !oe)
        else $error("STOP not recognised");
    sda_low_phase_a: assert property ($changed(oe) && !$past(start_c || stop_c)
                                      |-> !scl_s)
        else $error("data line changed while clock high");
    addr_ack_a: assert property (addr_acc |=> oe [*2])
        else $error("matching address not acknowledged");
    no_match_a: assert property (state == ST_IGNORE |-> !oe)
        else $error("driving the bus after a mismatch");
    read_nack_a: assert property (state == ST_RD_ACK |-> !oe)
        else $error("data line held during master acknowledge");
    upper_trip_a: assert property (s_hot |=> upper_trip)
        else $error("upper trip flag not set");
    lower_trip_a: assert property (s_cold |=> lower_trip)
        else $error("lower trip flag not set");
    alarm_level_a: assert property (s_hot |-> ##2 ALARM_OUTPUT_O == $past(pol_q))
        else $error("alarm pin level wrong for active level");
    alarm_hold_a: assert property ($stable(alarm_q) && $stable(pol_q)
                                   |=> $stable(ALARM_OUTPUT_O))
        else $error("alarm moved without a conversion");
endmodule : thsc_top
`default_nettype wire

// [bench/thsc_master.sv]
// Two-wire bus master model: drives the link clock, shares the data line
`timescale 1ns/1ps
`default_nettype none
module thsc_master (
    input  wire logic       clk_i,
    input  wire logic       sda_i,
    output logic            scl_o,
    output logic            sda_low_o,
    output logic [8:0]      got_o,
    output logic            got_stb_o
);
    // Bus idle: both lines released
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
        got_o     = 9'h000;
        got_stb_o = 1'b0;
    end
    // Quarter phases are 2 cycles, so the link runs at 200 ns
    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask : w
    // Start or repeated start; waits out a late release by the slave
    task automatic start();
        sda_low_o = 1'b0;
        w(6);
        scl_o = 1'b1;
        w(4);
        sda_low_o = 1'b1;
        w(4);
        scl_o = 1'b0;
    endtask : start
    // Stop: data rises while clock high
    task automatic stop();
        sda_low_o = 1'b1;
        w(6);
        scl_o = 1'b1;
        w(4);
        sda_low_o = 1'b0;
        w(4);
    endtask : stop
    // Eight bits and the ninth clock; line sampled mid high phase
    task automatic xfer(input logic [7:0] tx, input logic mack);
        logic [8:0] rx;
        for (int i = 8; i >= 0; i--) begin
            w(2);
            sda_low_o = (i > 0) ? ~tx[i-1] : mack;
            w(2);
            scl_o = 1'b1;
            w(2);
            rx[i] = sda_i;
            w(2);
            scl_o = 1'b0;
        end
        got_o = rx;
        got_stb_o = 1'b1;
        w(1);
        got_stb_o = 1'b0;
    endtask : xfer
endmodule : thsc_master
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench of the thermostat two-wire slave
`timescale 1ns/1ps
`default_nettype none
module tb
    import thsc_pkg::*;
;
    localparam logic [3:0] TYPE = 4'h5;   // Arbitrary value, same as the design default
    localparam int         NVC  = 2000;
    logic       clk;
    logic       rst_n;
    logic       scl;
    logic       m_low;
    logic       sda_o;
    logic       sda_oe;
    logic [2:0] sel;
    logic [8:0] temp;
    logic [8:0] t;
    logic       tvalid;
    logic       run;
    logic       alarm;
    logic [8:0] got;
    logic       got_stb;
    logic [8:0] expq[$];
    int         err_count;
    int         samples_checked;
    // Open-drain line with pull-up
    wire        sda = ~((sda_oe & ~sda_o) | m_low);

    thsc_top #(.DEV_TYPE_CODE(TYPE), .NV_CYC(NVC)) u_dut (
        .CLK_SYS_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda),
        .SDA_O(sda_o), .SDA_OE_O(sda_oe), .ADDR_SELECT_I(sel), .TEMP_I(temp),
        .TEMP_VALID_I(tvalid), .CONV_RUN_O(run), .ALARM_OUTPUT_O(alarm));
    thsc_master u_master (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low),
        .got_o(got), .got_stb_o(got_stb));

    // 40 MHz system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("mismatches %0d, checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    // Written byte; the ninth bit is low only when acknowledged
    task automatic wb(input logic [7:0] b, input logic ack = 1'b1);
        expq.push_back({b, ~ack});
        u_master.xfer(b, 1'b0);
    endtask : wb
    function automatic logic [7:0] adr(input logic r);
        return {TYPE, sel, r};
    endfunction : adr
    // Command plus n data bytes, high byte first
    task automatic cmd(input logic [7:0] c, input logic [15:0] d, input int n);
        u_master.start();
        wb(adr(1'b0));
        wb(c);
        for (int i = 0; i < n; i++) wb(d[15-8*i -: 8]);
        u_master.stop();
    endtask : cmd
    // Command, repeated start, n bytes read; last left unacknowledged
    task automatic rd(input logic [7:0] c, input logic [15:0] e, input int n);
        u_master.start();
        wb(adr(1'b0));
        wb(c);
        u_master.start();
        wb(adr(1'b1));
        for (int i = 0; i < n; i++) begin
            expq.push_back({e[15-8*i -: 8], i == n - 1});
            u_master.xfer(8'hff, i != n - 1);
        end
        u_master.stop();
    endtask : rd
    // Measuring core: one finished conversion
    task automatic conv(input logic [8:0] v);
        @(negedge clk);
        temp = v;
        tvalid = 1'b1;
        @(negedge clk);
        tvalid = 1'b0;
        repeat (4) @(negedge clk);
    endtask : conv
    // Oldest note against each finished byte
    always @(posedge got_stb) begin
        chk(got, expq.pop_front());
    end
    // Watchdog far beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        err_count = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        temp = 9'h000;
        tvalid = 1'b0;
        void'($urandom(32'hd13c));
        sel = 3'($urandom());
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(9'(alarm), 9'h001);
        rd(CMD_CONFIG, 16'h8800, 1);
        // Wrong type code, then wrong select bits: never acknowledged
        u_master.start();
        wb({TYPE ^ 4'h1, sel, 1'b0}, 1'b0);
        wb(CMD_CONFIG, 1'b0);
        u_master.stop();
        u_master.start();
        wb({TYPE, ~sel, 1'b0}, 1'b0);
        u_master.stop();
        cmd(CMD_CONFIG, 16'hf300, 1);
        rd(CMD_CONFIG, 16'h9b00, 1);
        chk(9'(alarm), 9'h000);
        repeat (NVC) @(negedge clk);
        cmd(CMD_UPPER_LIM, 16'h1900, 2);
        repeat (NVC) @(negedge clk);
        cmd(CMD_LOWER_LIM, 16'h0800, 2);
        repeat (NVC) @(negedge clk);
        rd(CMD_UPPER_LIM, 16'h1900, 2);
        rd(CMD_LOWER_LIM, 16'h0800, 2);
        // Single conversion above the upper limit
        cmd(CMD_START_CONV, 16'h0000, 0);
        chk(9'(run), 9'h001);
        rd(CMD_CONFIG, 16'h0b00, 1);
        conv(9'h040);
        chk(9'(run), 9'h000);
        chk(9'(alarm), 9'h001);
        rd(CMD_READ_TEMP, 16'h2000, 2);
        rd(CMD_CONFIG, 16'hcb00, 1);
        chk(9'(alarm), 9'h001);
        // Continuous mode, random negative reading, then stop
        cmd(CMD_CONFIG, 16'h0200, 1);
        repeat (NVC) @(negedge clk);
        rd(CMD_CONFIG, 16'h8a00, 1);
        cmd(CMD_START_CONV, 16'h0000, 0);
        t = {1'b1, 8'($urandom())};
        conv(t);
        chk(9'(run), 9'h001);
        chk(9'(alarm), 9'h000);
        rd(CMD_READ_TEMP, {t, 7'h00}, 2);
        cmd(CMD_STOP_CONV, 16'h0000, 0);
        chk(9'(run), 9'h001);
        conv(9'h020);
        chk(9'(run), 9'h000);
        rd(CMD_CONFIG, 16'haa00, 1);
        repeat (20) @(negedge clk);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
